// file: sptx_pkg.sv
package sptx_pkg;
	// register indices, one per channel
	localparam logic [2:0] REG_DATA   = 3'h0;
	localparam logic [2:0] REG_CMD    = 3'h1;
	localparam logic [2:0] REG_TXCTL  = 3'h2;
	localparam logic [2:0] REG_MODE   = 3'h3;
	localparam logic [2:0] REG_SYNCLO = 3'h4;
	localparam logic [2:0] REG_SYNCHI = 3'h5;
	localparam logic [2:0] REG_STATUS = 3'h6;
	// transmit control fields
	localparam int TC_CRC_EN = 0;
	localparam int TC_TX_EN  = 3;
	localparam int TC_BREAK  = 4;
	localparam int TC_BITS   = 5;
	// mode fields
	localparam int MD_PROTO  = 0;
	localparam int MD_PAR_EN = 2;
	localparam int MD_PAR_EV = 3;
	localparam int MD_STOP2  = 4;
	localparam int MD_POLY   = 5;
	localparam int MD_SYN16  = 6;
	// commands
	localparam logic [7:0] CMD_SW_RESET  = 8'h18;
	localparam logic [7:0] CMD_RST_TXINT = 8'h28;
	localparam logic [7:0] CMD_RST_CRC   = 8'h80;
	localparam logic [7:0] CMD_RST_IDLE  = 8'hC0;
	localparam logic [7:0] CMD_ABORT     = 8'h08;
	// status fields
	localparam int ST_BUF_EMPTY  = 2;
	localparam int ST_BECOMING   = 0;
	localparam int ST_IDLE_CRC   = 6;
	localparam int ST_ALL_SENT   = 1;
	localparam logic [1:0] PROTO_ASYNC = 2'h0;
	localparam logic [1:0] PROTO_COP   = 2'h1;
	localparam logic [1:0] PROTO_BOP   = 2'h2;
	localparam logic [7:0] FLAG_PAT    = 8'h7E;
	localparam logic [15:0] POLY_A     = 16'h8005;
	localparam logic [15:0] POLY_B     = 16'h1021;
	localparam logic [3:0] ABORT_ONES  = 4'hA;
	localparam logic [2:0] ONES_LIMIT  = 3'h5;
	localparam logic [7:0] REG_RESET   = 8'h00;

	typedef enum {TS_OFF, TS_START, TS_DATA, TS_PAR, TS_STOP, TS_SYNC, TS_CRC,
		TS_FLAG, TS_ABORT} sptx_state_e;

	typedef struct packed {
		logic [7:0] txctl;
		logic [7:0] mode;
		logic [7:0] synclo;
		logic [7:0] synchi;
	} sptx_cfg_s;
endpackage

// file: sptx_channel.sv
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
// one transmit channel; the top holds two of these
module sptx_channel
	import sptx_pkg::*;
(
	input  wire logic       clk_in,
	input  wire logic       rstn_in,
	input  wire logic       wr_in,
	input  wire logic [2:0] addr_in,
	input  wire logic [7:0] wdata_in,
	input  wire logic       tx_bit_clock_in,
	output logic      [7:0] status_out,
	output logic      [7:0] rdreg_out,
	output logic            txd_out
);
	// ****************************************
	// bit clock falling edge
	// ****************************************
	logic clk_s1, clk_s2, clk_s3;
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			clk_s1 <= 1'b1;
			clk_s2 <= 1'b1;
			clk_s3 <= 1'b1;
		end else begin
			clk_s1 <= tx_bit_clock_in;
			clk_s2 <= clk_s1;
			clk_s3 <= clk_s2;
		end
	end
	wire logic bit_tick = clk_s3 & ~clk_s2;

	// ****************************************
	// registers
	// ****************************************
	sptx_cfg_s   cfg;
	logic [7:0]  buf_data;
	logic        buf_full;
	logic        becoming;
	logic        idle_crc;
	logic        abort_req;
	logic        crc_rst_req;
	wire logic   wr_data = wr_in && addr_in == REG_DATA;
	wire logic   wr_cmd  = wr_in && addr_in == REG_CMD;
	wire logic   sw_rst  = wr_cmd && wdata_in == CMD_SW_RESET;
	logic        load;

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cfg <= '0;
		end else if (sw_rst) begin
			cfg <= '0;
		end else if (wr_in) begin
			case (addr_in)
				REG_TXCTL:  cfg.txctl <= wdata_in;
				REG_MODE:   cfg.mode <= wdata_in;
				REG_SYNCLO: cfg.synclo <= wdata_in;
				REG_SYNCHI: cfg.synchi <= wdata_in;
				default:    cfg.txctl <= cfg.txctl;
			endcase
		end
	end

	// buffer register and its flags
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			buf_data <= REG_RESET;
			buf_full <= 1'b0;
			becoming <= 1'b0;
		end else if (sw_rst) begin
			buf_full <= 1'b0;
			becoming <= 1'b0;
		end else begin
			if (wr_data) begin
				buf_data <= wdata_in;
				buf_full <= 1'b1;
			end else if (load) begin
				buf_full <= 1'b0;
			end
			// set by the transfer; a same-cycle write still loses to it
			if (load)
				becoming <= 1'b1;
			else if (wr_data || (wr_cmd && wdata_in == CMD_RST_TXINT))
				becoming <= 1'b0;
		end
	end

	// ****************************************
	// transmitter
	// ****************************************
	sptx_state_e state;
	logic [7:0]  shreg;
	logic [3:0]  cnt;
	logic        par;
	logic        crc_on;
	logic [15:0] crc;
	logic [2:0]  ones;
	logic        stuff;
	logic        txd_r;

	wire logic [1:0] proto = cfg.mode[MD_PROTO +: 2];
	wire logic       tx_en = cfg.txctl[TC_TX_EN];
	wire logic       brk   = cfg.txctl[TC_BREAK];
	wire logic [15:0] poly = cfg.mode[MD_POLY] ? POLY_B : POLY_A;
	wire logic       sync16 = cfg.mode[MD_SYN16];

	function automatic logic [3:0] char_bits(input logic [1:0] f);
		char_bits = 4'h5 + {2'b00, f};
	endfunction

	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b,
		input logic [15:0] p);
		crc_step = c[15] ^ b ? ({c[14:0], 1'b0} ^ p) : {c[14:0], 1'b0};
	endfunction

	// run of ones after bit b, for zero insertion
	function automatic logic [2:0] ones_after(input logic [2:0] run, input logic b);
		ones_after = b ? run + 3'h1 : 3'h0;
	endfunction

	function automatic logic stuff_after(input logic [2:0] run, input logic b);
		stuff_after = b && run == ONES_LIMIT - 3'h1;
	endfunction

	// bits subject to stuffing: data and check in bit-oriented mode
	wire logic stuffable = proto == PROTO_BOP && (state == TS_DATA || state == TS_CRC);
	// sync, flag and stop bits finish first; char sync modes never start without a sync
	assign load = bit_tick && buf_full && !brk && tx_en && !abort_req && !stuff &&
		((state == TS_OFF && proto != PROTO_COP) || (state == TS_STOP && cnt <= 4'h1) ||
		((state == TS_SYNC || state == TS_FLAG) && cnt == 4'h0) ||
		(proto != PROTO_ASYNC && ((state == TS_DATA && cnt == 4'h1) ||
		(state == TS_CRC && cnt == 4'h0))));

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			abort_req   <= 1'b0;
			crc_rst_req <= 1'b0;
			idle_crc    <= 1'b1;
		end else if (sw_rst) begin
			abort_req   <= 1'b0;
			crc_rst_req <= 1'b0;
			idle_crc    <= 1'b1;
		end else begin
			if (state == TS_ABORT)
				abort_req <= 1'b0;
			else if (wr_cmd && wdata_in == CMD_ABORT && proto == PROTO_BOP)
				abort_req <= 1'b1;
			// a command beside a bit tick is kept for the next tick
			if (wr_cmd && wdata_in == CMD_RST_CRC)
				crc_rst_req <= 1'b1;
			else if (bit_tick)
				crc_rst_req <= 1'b0;
			if (state == TS_CRC)
				idle_crc <= 1'b1;
			else if (wr_cmd && wdata_in == CMD_RST_IDLE)
				idle_crc <= 1'b0;
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state <= TS_OFF;
			shreg <= REG_RESET;
			cnt   <= 4'h0;
			par   <= 1'b0;
			crc_on <= 1'b0;
			crc   <= 16'h0000;
			ones  <= 3'h0;
			stuff <= 1'b0;
			txd_r <= 1'b1;
		end else if (sw_rst) begin
			state <= TS_OFF;
			txd_r <= 1'b1;
			ones  <= 3'h0;
			stuff <= 1'b0;
		end else if (bit_tick) begin
			if (crc_rst_req)
				crc <= 16'h0000;
			if (brk) begin
				state <= TS_OFF;
				txd_r <= 1'b1;
				ones  <= 3'h0;
				stuff <= 1'b0;
			end else if (stuff) begin
				txd_r <= 1'b0;
				stuff <= 1'b0;
				ones  <= 3'h0;
			end else if (abort_req && proto == PROTO_BOP) begin
				state <= TS_ABORT;
				cnt   <= ABORT_ONES;
				txd_r <= 1'b1;
				ones  <= 3'h0;
			end else if (load) begin
				shreg <= buf_data;
				crc_on <= cfg.txctl[TC_CRC_EN];
				// seeded so the sent bit is the complement of the running sum
				par   <= cfg.mode[MD_PAR_EV];
				if (proto == PROTO_ASYNC) begin
					state <= TS_START;
					txd_r <= 1'b0;
					cnt   <= char_bits(cfg.txctl[TC_BITS +: 2]);
				end else begin
					// first data bit goes out now; lsb first
					state <= TS_DATA;
					txd_r <= buf_data[0];
					shreg <= {1'b0, buf_data[7:1]};
					cnt   <= char_bits(cfg.txctl[TC_BITS +: 2]);
					if (cfg.txctl[TC_CRC_EN])
						crc <= crc_step(crc_rst_req ? 16'h0000 : crc, buf_data[0], poly);
					if (proto == PROTO_BOP) begin
						ones  <= ones_after(ones, buf_data[0]);
						stuff <= stuff_after(ones, buf_data[0]);
					end
				end
			end else begin
				case (state)
					TS_OFF, TS_STOP, TS_SYNC, TS_FLAG: begin
						// idle or end of frame: fill or mark
						ones <= 3'h0;
						if (state == TS_STOP && cnt > 4'h1) begin
							cnt <= cnt - 4'h1;
							txd_r <= 1'b1;
						end else if ((state == TS_SYNC || state == TS_FLAG) && cnt != 4'h0) begin
							// finish the sync character or flag, even when disabled
							cnt <= cnt - 4'h1;
							if (state == TS_SYNC && cnt == 4'h8) begin
								txd_r <= cfg.synchi[0];
								shreg <= {1'b0, cfg.synchi[7:1]};
							end else begin
								txd_r <= shreg[0];
								shreg <= {1'b0, shreg[7:1]};
							end
						end else if (!tx_en || proto == PROTO_ASYNC) begin
							state <= TS_OFF;
							txd_r <= 1'b1;
						end else if (proto == PROTO_COP) begin
							state <= TS_SYNC;
							shreg <= {1'b0, cfg.synclo[7:1]};
							cnt   <= sync16 ? 4'hF : 4'h7;
							txd_r <= cfg.synclo[0];
						end else begin
							// flag only closes a frame, then line marks
							state <= state == TS_FLAG ? TS_OFF : TS_OFF;
							txd_r <= 1'b1;
						end
					end
					TS_START: begin
						state <= TS_DATA;
						txd_r <= shreg[0];
						shreg <= {1'b0, shreg[7:1]};
						par   <= par ^ shreg[0];
					end
					TS_DATA, TS_CRC: begin
						if (state == TS_DATA && proto == PROTO_ASYNC) begin
							if (cnt == 4'h1) begin
								state <= cfg.mode[MD_PAR_EN] ? TS_PAR : TS_STOP;
								txd_r <= cfg.mode[MD_PAR_EN] ? ~par : 1'b1;
								cnt   <= cfg.mode[MD_STOP2] ? 4'h2 : 4'h1;
							end else begin
								cnt   <= cnt - 4'h1;
								txd_r <= shreg[0];
								shreg <= {1'b0, shreg[7:1]};
								par   <= par ^ shreg[0];
							end
						end else if (cnt == 4'h1 && state == TS_DATA && !idle_crc) begin
							state <= TS_CRC;
							// first check bit leaves now, fifteen follow
							cnt   <= 4'hF;
							txd_r <= crc[15];
							crc   <= {crc[14:0], 1'b0};
							ones  <= ones_after(ones, crc[15]);
							stuff <= stuffable && stuff_after(ones, crc[15]);
						end else if (state == TS_DATA ? cnt == 4'h1 : cnt == 4'h0) begin
							if (proto == PROTO_BOP) begin
								state <= TS_FLAG;
								shreg <= {1'b0, FLAG_PAT[7:1]};
								cnt   <= 4'h7;
								txd_r <= FLAG_PAT[0];
							end else begin
								state <= TS_OFF;
								txd_r <= 1'b1;
							end
						end else begin
							cnt <= cnt - 4'h1;
							if (state == TS_CRC) begin
								txd_r <= crc[15];
								crc   <= {crc[14:0], 1'b0};
								ones  <= ones_after(ones, crc[15]);
								stuff <= stuffable && stuff_after(ones, crc[15]);
							end else begin
								txd_r <= shreg[0];
								shreg <= {1'b0, shreg[7:1]};
								if (crc_on)
									crc <= crc_step(crc, shreg[0], poly);
								if (proto == PROTO_BOP) begin
									ones  <= ones_after(ones, shreg[0]);
									stuff <= stuff_after(ones, shreg[0]);
								end
							end
						end
					end
					TS_PAR: begin
						state <= TS_STOP;
						txd_r <= 1'b1;
					end
					TS_ABORT: begin
						txd_r <= 1'b1;
						if (cnt == 4'h1)
							state <= TS_OFF;
						else
							cnt <= cnt - 4'h1;
					end
					default: state <= TS_OFF;
				endcase
			end
		end
	end

	assign txd_out = txd_r & ~brk;

	// ****************************************
	// status and readback
	// ****************************************
	always_comb begin
		status_out = 8'h00;
		status_out[ST_BUF_EMPTY] = ~buf_full;
		status_out[ST_BECOMING]  = becoming;
		status_out[ST_IDLE_CRC]  = idle_crc;
		status_out[ST_ALL_SENT]  = ~buf_full && state == TS_OFF;
	end

	always_comb begin
		case (addr_in)
			REG_TXCTL:  rdreg_out = cfg.txctl;
			REG_MODE:   rdreg_out = cfg.mode;
			REG_SYNCLO: rdreg_out = cfg.synclo;
			REG_SYNCHI: rdreg_out = cfg.synchi;
			REG_STATUS: rdreg_out = status_out;
			default:    rdreg_out = 8'h00;
		endcase
	end
endmodule

// file: sptx_top.sv
`timescale 1ns/10ps
module sptx_top
	import sptx_pkg::*;
(
	input  wire logic       clk_in,
	input  wire logic       rstn_in,
	input  wire logic [3:0] addr_in,
	input  wire logic [7:0] wdata_in,
	input  wire logic       wr_in,
	input  wire logic       rd_in,
	input  wire logic [1:0] tx_bit_clock_in,
	output logic      [7:0] rdata_out,
	output logic      [1:0] txd_out
);
	logic [7:0] rdreg [2];
	// bit 3 of the address picks the channel
	for (genvar ch = 0; ch < 2; ch++) begin : g_ch
		sptx_channel u_ch (
			.clk_in          (clk_in),
			.rstn_in         (rstn_in),
			.wr_in           (wr_in && addr_in[3] == 1'(ch)),
			.addr_in         (addr_in[2:0]),
			.wdata_in        (wdata_in),
			.tx_bit_clock_in (tx_bit_clock_in[ch]),
			.status_out      (),
			.rdreg_out       (rdreg[ch]),
			.txd_out         (txd_out[ch])
		);
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in)
			rdata_out <= 8'h00;
		else if (rd_in)
			rdata_out <= rdreg[addr_in[3]];
		else
			rdata_out <= 8'h00;
	end
endmodule

// file: sptx_monitor.sv
`timescale 1ns/10ps
// ****************
// line checker
// ****************
module sptx_monitor
	import sptx_pkg::*;
(
	input  wire logic       clk_in,
	input  wire logic       rstn_in,
	input  wire logic [3:0] addr_in,
	input  wire logic [7:0] wdata_in,
	input  wire logic       wr_in,
	input  wire logic       rd_in,
	input  wire logic [1:0] tx_bit_clock_in,
	input  wire logic [7:0] rdata_out,
	input  wire logic [1:0] txd_out
);
	logic       clk_q;
	logic [3:0] fall_age;
	logic [3:0] wr_age;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	// ages saturate so a long idle spell never wraps into a false pass
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			clk_q    <= 1'b1;
			fall_age <= 4'hF;
		end else begin
			clk_q    <= tx_bit_clock_in[0];
			fall_age <= (clk_q && !tx_bit_clock_in[0]) ? 4'h0 :
				((fall_age == 4'hF) ? fall_age : fall_age + 4'h1);
		end
	end
	// only channel 0 writes count: channel 1 must never move channel 0
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			wr_age <= 4'hF;
		end else begin
			wr_age <= (wr_in && !addr_in[3]) ? 4'h0 :
				((wr_age == 4'hF) ? wr_age : wr_age + 4'h1);
		end
	end
	sequence s_brk0;
		wr_in && addr_in == {1'b0, REG_TXCTL} && wdata_in[TC_BREAK];
	endsequence
	sequence s_brk1;
		wr_in && addr_in == {1'b1, REG_TXCTL} && wdata_in[TC_BREAK];
	endsequence
	property p_reset_mark;
		$rose(rstn_in) |-> txd_out == 2'h3;
	endproperty
	property p_rd_idle;
		!$past(rd_in) |-> rdata_out == 8'h00;
	endproperty
	property p_unmapped;
		rd_in && addr_in[2:0] == 3'h7 |=> rdata_out == 8'h00;
	endproperty
	property p_break0;
		s_brk0 |=> !txd_out[0] [*3];
	endproperty
	property p_break1;
		s_brk1 |=> !txd_out[1] ##1 txd_out[0] == $past(txd_out[0]);
	endproperty
	property p_sw_reset;
		wr_in && addr_in == {1'b0, REG_CMD} && wdata_in == CMD_SW_RESET |-> ##[1:4] txd_out[0];
	endproperty
	property p_bit_edge;
		$changed(txd_out[0]) |-> fall_age <= 4'h6 || wr_age <= 4'h5;
	endproperty
	property p_bit_hold;
		$changed(txd_out[0]) && wr_age > 4'h5 |=> ($stable(txd_out[0]) || wr_age <= 4'h1) [*5];
	endproperty
	a_reset_mark: assert property (p_reset_mark) else $error("line not marking");
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside its cycle");
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	a_break0: assert property (p_break0) else $error("break did not space line 0");
	a_break1: assert property (p_break1) else $error("break on 1 not isolated");
	a_sw_reset: assert property (p_sw_reset) else $error("no mark after soft reset");
	a_bit_edge: assert property (p_bit_edge) else $error("bit moved off clock fall");
	a_bit_hold: assert property (p_bit_hold) else $error("bit shorter than period");
endmodule
bind sptx_top sptx_monitor i_sptx_monitor (.clk_in(clk_in), .rstn_in(rstn_in), .addr_in(addr_in),
	.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .tx_bit_clock_in(tx_bit_clock_in),
	.rdata_out(rdata_out), .txd_out(txd_out));

// file: sptx_line_model.sv
`timescale 1ns/10ps
// ****************
// far station: free-running modem clock, async receiver
// ****************
module sptx_line_model #(
	parameter int  NBITS = 8,
	parameter int  PAR   = 0,
	parameter time PHASE = 0
) (
	input  wire logic txd_in,
	output logic      bit_clk_out
);
	logic [7:0]  q[$];
	logic [15:0] raw = 16'h0000;
	logic [7:0]  ch;
	int          errs = 0;
	initial begin
		bit_clk_out = 1'b1;
		#(PHASE);
		forever #200 bit_clk_out = ~bit_clk_out;
	end
	// newest bit enters at the top, so lsb-first bytes read straight
	always @(posedge bit_clk_out) raw <= {txd_in, raw[15:1]};
	initial begin
		forever begin
			@(posedge bit_clk_out);
			if (txd_in === 1'b0) begin
				ch = 8'h00;
				for (int i = 0; i < NBITS; i++) begin
					@(posedge bit_clk_out);
					ch[i] = txd_in;
				end
				if (PAR != 0) begin
					@(posedge bit_clk_out);
					if (((^ch) ^ txd_in) !== (PAR == 2)) errs++;
				end
				@(posedge bit_clk_out);
				if (txd_in !== 1'b1) errs++;
				q.push_back(ch);
			end
		end
	end
endmodule

// file: testbench.sv
`timescale 1ns/10ps
// ****************
// bench
// ****************
module testbench
	import sptx_pkg::*;
;
	logic       clk_in;
	logic       rstn_in;
	logic [3:0] addr_in;
	logic [7:0] wdata_in;
	logic       wr_in;
	logic       rd_in;
	logic [1:0] bclk;
	logic [7:0] rdata_out;
	logic [1:0] txd_out;
	logic [7:0] d;
	int         miscompares;
	int         cmp_count;
	int         lows;
	logic       found;
	sptx_top i_sptx_top (.clk_in(clk_in), .rstn_in(rstn_in), .addr_in(addr_in), .wdata_in(wdata_in),
		.wr_in(wr_in), .rd_in(rd_in), .tx_bit_clock_in(bclk), .rdata_out(rdata_out),
		.txd_out(txd_out));
	sptx_line_model #(.PAR(1), .PHASE(7)) i_sptx_line_model (.txd_in(txd_out[0]),
		.bit_clk_out(bclk[0]));
	sptx_line_model #(.PAR(2), .PHASE(113)) i_sptx_line_model_b (.txd_in(txd_out[1]),
		.bit_clk_out(bclk[1]));
	initial begin
		clk_in = 1'b0;
		forever #25 clk_in = ~clk_in;
	end
	task automatic finish_test();
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
			miscompares++;
		end
	endtask
	// a gap cycle before each strobe keeps one assignment per step
	task automatic wr_reg(input logic ch, input logic [2:0] idx, input logic [7:0] v);
		@(posedge clk_in);
		addr_in  <= {ch, idx};
		wdata_in <= v;
		wr_in    <= 1'b1;
		@(posedge clk_in);
		wr_in    <= 1'b0;
	endtask
	task automatic rd_reg(input logic ch, input logic [2:0] idx, output logic [7:0] v);
		@(posedge clk_in);
		addr_in <= {ch, idx};
		rd_in   <= 1'b1;
		@(posedge clk_in);
		rd_in   <= 1'b0;
		@(posedge clk_in);
		v = rdata_out;
	endtask
	initial begin
		#500000;
		$display("[FAIL] %0t watchdog expired", $time);
		miscompares++;
		finish_test();
	end
	initial begin
		rstn_in = 1'b0;
		addr_in = 4'h0;
		wdata_in = 8'h00;
		wr_in = 1'b0;
		rd_in = 1'b0;
		miscompares = 0;
		cmp_count = 0;
		repeat (12) @(posedge clk_in);
		rstn_in <= 1'b1;
		@(posedge clk_in);
		chk8(8'(txd_out), 8'h03);
		rd_reg(1'b0, REG_STATUS, d);
		chk8(8'(d[ST_BUF_EMPTY]), 8'h01);
		rd_reg(1'b1, 3'h7, d);
		chk8(d, 8'h00);
		$display("test reset done");
		wr_reg(1'b0, REG_MODE, 8'h0C);
		wr_reg(1'b1, REG_MODE, 8'h04);
		wr_reg(1'b0, REG_TXCTL, 8'h68);
		wr_reg(1'b1, REG_TXCTL, 8'h68);
		wr_reg(1'b1, REG_DATA, 8'h81);
		wr_reg(1'b0, REG_DATA, 8'hA5);
		repeat (12) @(posedge clk_in);
		rd_reg(1'b0, REG_STATUS, d);
		chk8({6'h00, d[ST_BUF_EMPTY], d[ST_BECOMING]}, 8'h03);
		wr_reg(1'b0, REG_DATA, 8'h3C);
		rd_reg(1'b0, REG_STATUS, d);
		chk8({6'h00, d[ST_BUF_EMPTY], d[ST_BECOMING]}, 8'h00);
		for (int n = 0; n < 600 && i_sptx_line_model.q.size() < 2; n++) @(posedge clk_in);
		chk8(8'(i_sptx_line_model.q.size()), 8'h02);
		chk8(i_sptx_line_model.q[0], 8'hA5);
		chk8(i_sptx_line_model.q[1], 8'h3C);
		chk8(i_sptx_line_model_b.q[0], 8'h81);
		chk8(8'(i_sptx_line_model.errs + i_sptx_line_model_b.errs), 8'h00);
		$display("test async done");
		wr_reg(1'b0, REG_DATA, 8'h55);
		repeat (40) @(posedge clk_in);
		wr_reg(1'b0, REG_TXCTL, 8'h78);
		repeat (100) @(posedge clk_in);
		chk8(8'(txd_out), 8'h02);
		wr_reg(1'b0, REG_TXCTL, 8'h60);
		repeat (6) @(posedge clk_in);
		lows = 0;
		repeat (200) begin
			@(posedge clk_in);
			if (txd_out[0] !== 1'b1) lows++;
		end
		chk8(8'(lows), 8'h00);
		$display("test break done");
		for (int c = 0; c < 2; c++) begin
			wr_reg(c[0], REG_TXCTL, 8'h78);
			repeat (4) @(posedge clk_in);
			chk8(8'(txd_out[c]), 8'h00);
			wr_reg(c[0], REG_CMD, CMD_SW_RESET);
			repeat (6) @(posedge clk_in);
			chk8(8'(txd_out[c]), 8'h01);
		end
		$display("test soft reset done");
		wr_reg(1'b1, REG_SYNCLO, 8'h96);
		wr_reg(1'b1, REG_MODE, 8'(PROTO_COP));
		wr_reg(1'b1, REG_TXCTL, 8'h68);
		found = 1'b0;
		repeat (40) begin
			@(posedge bclk[1]);
			if (i_sptx_line_model_b.raw === 16'h9696) found = 1'b1;
		end
		chk8(8'(found), 8'h01);
		$display("test sync fill done");
		// all-ones byte: zero after five ones, then the closing flag
		wr_reg(1'b1, REG_MODE, 8'(PROTO_BOP));
		wr_reg(1'b1, REG_DATA, 8'hFF);
		found = 1'b0;
		repeat (40) begin
			@(posedge bclk[1]);
			if (i_sptx_line_model_b.raw === 16'h7EEF) found = 1'b1;
		end
		chk8(8'(found), 8'h01);
		$display("test bit framing done");
		finish_test();
	end
endmodule
